// ---- rtl/mis_core.sv ----
// Function
// RULE1: add with carry into work register
// RULE2: add with carry written back to memory
// RULE3: plain add memory into work register
// RULE4: immediate add into work register
// RULE5: plain add written back to memory
// RULE6: and into work register, zero only
// RULE7: and written back to memory, zero only
// RULE8: call pushes next address, loads target
// RULE9: clear byte writes zero, flags kept
// RULE10: clear bit zeroes one bit only
// RULE11: watchdog clear zeroes counter and flags
// RULE12: both preclears needed to clear watchdog
// RULE13: single preclear only records its marker
// RULE14: invert to memory or work, zero only
// RULE15: decimal adjust low nibble, internal carry
// RULE16: decimal adjust high nibble, carry only
// RULE17: decrement to memory or work, zero only
// RULE18: increment to memory or work, zero only
// RULE19: power down halts, keeps state, pc advances
// RULE20: power down clears watchdog, sets sleep
// RULE21: jump loads target, stack untouched
// RULE22: program counter low write adds cycle
// RULE23: jump and call take two cycles
// RULE24: add flags from bit 3, bit 7
// RULE25: unlisted flags keep their value
`timescale 1ns/100ps
`default_nettype none
`include "mis_defines.svh"

module mis_core #(
	parameter int ADDR_W = 6,
	parameter int STACK_DEPTH = 4,
	parameter int PRESCALE_W = `MIS_WDT_PRESCALE_W
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire mis_pkg::mis_req_type req,
	input wire logic wake_up,
	input wire logic [ADDR_W-1:0] peek_addr,
	output logic req_ready,
	output logic done,
	output logic [7:0] work_reg,
	output mis_pkg::mis_flags_type flags,
	output logic [9:0] pc,
	output logic [7:0] watchdog_counter,
	output logic clock_stopped,
	output logic [7:0] peek_data
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
	localparam int DEPTH = 1 << ADDR_W;

	typedef struct packed {
		mis_pkg::mis_fsm_type fsm;
		logic [3:0] cnt;
		logic ready;
		logic done;
		logic [7:0] acc;
		mis_pkg::mis_flags_type fl;
		logic [9:0] pc;
		logic [DEPTH-1:0][7:0] ram;
		logic [STACK_DEPTH-1:0][9:0] stack;
		logic [SP_W-1:0] sp;
		logic [7:0] wdt;
		logic [PRESCALE_W-1:0] prescale;
		logic [1:0] clk_div;
		logic pre_one;
		logic pre_two;
		logic sleep_req;
		logic [7:0] peek;
	} mis_state_type;

	mis_state_type st;
	mis_state_type next_st;

	// returns {sign_wrap, half_carry, carry, sum}
	function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
			input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		logic [7:0] s;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		s = {hi[3:0], lo[3:0]};
		add8 = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], hi[4], s}; // RULE24
	endfunction

	function automatic logic is_pcl(input logic [7:0] a);
		is_pcl = (a == `MIS_PCL_ADDR);
	endfunction

	function automatic logic [7:0] mem_read(input mis_state_type s, input logic [7:0] a);
		mem_read = is_pcl(a) ? s.pc[7:0] : s.ram[a[ADDR_W-1:0]];
	endfunction

	always_comb begin
		logic [7:0] m;
		logic [10:0] sum;
		logic [7:0] res;
		logic mem_wr;
		logic acc_wr;
		logic [3:0] lo_n;
		logic [4:0] hi_n;
		logic ac1;
		logic [1:0] cycles;
		logic [9:0] pc_next;
		logic wdt_clear;
		m = '0;
		sum = '0;
		res = '0;
		mem_wr = 1'b0;
		acc_wr = 1'b0;
		lo_n = '0;
		hi_n = '0;
		ac1 = 1'b0;
		cycles = 2'(`MIS_BASE_CYCLES);
		pc_next = '0;
		wdt_clear = 1'b0;
		next_st = st; // RULE25
		next_st.done = 1'b0;
		next_st.peek = mem_read(st, 8'(peek_addr));

		// watchdog prescaler steps once per instruction cycle while the clock is alive
		if (st.fsm != mis_pkg::MIS_FSM_HALTED) begin
			next_st.clk_div = st.clk_div + 2'd1;
			if (st.clk_div == 2'(`MIS_CYCLE_CLKS - 1)) begin
				next_st.prescale = st.prescale + 1'b1;
				if (&st.prescale) begin
					next_st.wdt = st.wdt + 8'd1;
					if (&st.wdt) begin
						next_st.fl.watchdog_expired_flag = 1'b1;
					end
				end
			end
		end

		unique case (st.fsm)
			mis_pkg::MIS_FSM_IDLE: begin
				if (req_valid) begin
					m = mem_read(st, req.addr);
					pc_next = st.pc + 10'd1;
					unique case (req.op)
						mis_pkg::MIS_OP_SUM_CARRY_TO_WORK,
						mis_pkg::MIS_OP_SUM_WITH_CARRY_TO_MEMORY,
						mis_pkg::MIS_OP_SUM_TO_WORK,
						mis_pkg::MIS_OP_SUM_IMMEDIATE,
						mis_pkg::MIS_OP_SUM_TO_MEMORY: begin
							if (req.op == mis_pkg::MIS_OP_SUM_IMMEDIATE) begin
								m = req.imm; // RULE4
							end
							sum = add8(st.acc, m,
								(req.op == mis_pkg::MIS_OP_SUM_CARRY_TO_WORK ||
								req.op == mis_pkg::MIS_OP_SUM_WITH_CARRY_TO_MEMORY) &&
								st.fl.carry); // RULE1 RULE2 RULE3
							res = sum[7:0];
							next_st.fl.sign_wrap_flag = sum[10]; // RULE24
							next_st.fl.half_carry_flag = sum[9];
							next_st.fl.carry = sum[8];
							next_st.fl.zero = (res == 8'h00);
							mem_wr = (req.op == mis_pkg::MIS_OP_SUM_WITH_CARRY_TO_MEMORY ||
								req.op == mis_pkg::MIS_OP_SUM_TO_MEMORY); // RULE2 RULE5
							acc_wr = !mem_wr; // RULE1 RULE3 RULE4
						end
						mis_pkg::MIS_OP_CONJ_TO_WORK,
						mis_pkg::MIS_OP_CONJ_IMMEDIATE,
						mis_pkg::MIS_OP_BITWISE_CONJUNCTION_TO_MEMORY: begin
							if (req.op == mis_pkg::MIS_OP_CONJ_IMMEDIATE) begin
								m = req.imm;
							end
							res = st.acc & m; // RULE6
							next_st.fl.zero = (res == 8'h00);
							mem_wr = (req.op == mis_pkg::MIS_OP_BITWISE_CONJUNCTION_TO_MEMORY); // RULE7
							acc_wr = !mem_wr;
						end
						mis_pkg::MIS_OP_SUBROUTINE_CALL: begin
							// overflow wraps the stack pointer, as a fixed-depth stack does
							next_st.stack[st.sp] = st.pc + 10'd1; // RULE8
							next_st.sp = st.sp + 1'b1;
							pc_next = req.target;
							cycles = 2'(`MIS_BRANCH_CYCLES); // RULE23
						end
						mis_pkg::MIS_OP_DIRECT_BRANCH: begin
							pc_next = req.target; // RULE21
							cycles = 2'(`MIS_BRANCH_CYCLES); // RULE23
						end
						mis_pkg::MIS_OP_CLEAR_BYTE: begin
							res = `MIS_CLEAR_BYTE; // RULE9
							mem_wr = 1'b1;
						end
						mis_pkg::MIS_OP_CLEAR_BIT: begin
							res = m & ~(8'h01 << req.bit_sel); // RULE10
							mem_wr = 1'b1;
						end
						mis_pkg::MIS_OP_WATCHDOG_CLEAR: begin
							wdt_clear = 1'b1; // RULE11
						end
						mis_pkg::MIS_OP_GUARD_PRECLEAR_ONE: begin
							if (st.pre_two) begin
								wdt_clear = 1'b1; // RULE12
							end else begin
								next_st.pre_one = 1'b1; // RULE13
							end
						end
						mis_pkg::MIS_OP_GUARD_PRECLEAR_TWO: begin
							if (st.pre_one) begin
								wdt_clear = 1'b1; // RULE12
							end else begin
								next_st.pre_two = 1'b1; // RULE13
							end
						end
						mis_pkg::MIS_OP_INVERT_BITS,
						mis_pkg::MIS_OP_INVERT_BITS_TO_WORK: begin
							res = ~m; // RULE14
							next_st.fl.zero = (res == 8'h00);
							mem_wr = (req.op == mis_pkg::MIS_OP_INVERT_BITS);
							acc_wr = !mem_wr;
						end
						mis_pkg::MIS_OP_DECIMAL_FIXUP: begin
							if (st.acc[3:0] > `MIS_BCD_LIMIT || st.fl.half_carry_flag) begin
								lo_n = st.acc[3:0] + `MIS_BCD_FIX; // RULE15
								ac1 = !st.fl.half_carry_flag;
							end else begin
								lo_n = st.acc[3:0];
								ac1 = 1'b0;
							end
							hi_n = {1'b0, st.acc[7:4]} + {4'h0, ac1};
							if (hi_n > {1'b0, `MIS_BCD_LIMIT} || st.fl.carry) begin
								hi_n = hi_n + {1'b0, `MIS_BCD_FIX}; // RULE16
								next_st.fl.carry = 1'b1;
							end
							res = {hi_n[3:0], lo_n};
							mem_wr = 1'b1;
						end
						mis_pkg::MIS_OP_DECREMENT,
						mis_pkg::MIS_OP_DECREMENT_TO_WORK: begin
							res = m - 8'd1; // RULE17
							next_st.fl.zero = (res == 8'h00);
							mem_wr = (req.op == mis_pkg::MIS_OP_DECREMENT);
							acc_wr = !mem_wr;
						end
						mis_pkg::MIS_OP_INCREMENT,
						mis_pkg::MIS_OP_INCREMENT_TO_WORK: begin
							res = m + 8'd1; // RULE18
							next_st.fl.zero = (res == 8'h00);
							mem_wr = (req.op == mis_pkg::MIS_OP_INCREMENT);
							acc_wr = !mem_wr;
						end
						mis_pkg::MIS_OP_POWER_DOWN: begin
							wdt_clear = 1'b1; // RULE20
						end
						default: begin
						end
					endcase
					if (acc_wr) begin
						next_st.acc = res;
					end
					next_st.pc = pc_next;
					if (mem_wr) begin
						if (is_pcl(req.addr)) begin
							// the written byte overrides the sequential advance
							next_st.pc = {st.pc[9:8], res};
							cycles = cycles + 2'(`MIS_PCL_EXTRA_CYCLES); // RULE22
						end else begin
							next_st.ram[req.addr[ADDR_W-1:0]] = res;
						end
					end
					if (wdt_clear) begin
						next_st.wdt = `MIS_WDT_RESET; // RULE11 RULE12 RULE20
						next_st.prescale = '0;
						next_st.clk_div = '0;
						next_st.pre_one = 1'b0;
						next_st.pre_two = 1'b0;
						next_st.fl.watchdog_expired_flag = 1'b0;
						next_st.fl.sleep_entered_flag =
							(req.op == mis_pkg::MIS_OP_POWER_DOWN); // RULE20
					end
					next_st.cnt = 4'(cycles * `MIS_CYCLE_CLKS - 1); // RULE22 RULE23
					next_st.fsm = mis_pkg::MIS_FSM_BUSY;
					next_st.ready = 1'b0;
					next_st.sleep_req = (req.op == mis_pkg::MIS_OP_POWER_DOWN); // RULE19
				end
			end
			mis_pkg::MIS_FSM_BUSY: begin
				next_st.cnt = st.cnt - 4'd1;
				if (st.cnt == 4'd1) begin
					next_st.done = 1'b1;
					if (st.ready) begin
						next_st.ready = 1'b0;
					end
				end
				if (st.cnt == 4'd0) begin
					// power down parks here; pc already points past it
					// own marker, so a stale sleep flag never parks a later op
					if (st.sleep_req) begin
						next_st.sleep_req = 1'b0;
						next_st.fsm = mis_pkg::MIS_FSM_HALTED; // RULE19
					end else begin
						next_st.fsm = mis_pkg::MIS_FSM_IDLE;
						next_st.ready = 1'b1;
					end
				end
			end
			mis_pkg::MIS_FSM_HALTED: begin
				if (wake_up) begin
					next_st.fsm = mis_pkg::MIS_FSM_IDLE;
					next_st.ready = 1'b1;
				end
			end
			default: begin
				next_st.fsm = mis_pkg::MIS_FSM_IDLE;
				next_st.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st <= '0;
			st.fsm <= mis_pkg::MIS_FSM_IDLE;
			st.ready <= 1'b1;
			st.acc <= `MIS_ACC_RESET;
			st.pc <= `MIS_PC_RESET;
			st.wdt <= `MIS_WDT_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign req_ready = st.ready;
	assign done = st.done;
	assign work_reg = st.acc;
	assign flags = st.fl;
	assign pc = st.pc;
	assign watchdog_counter = st.wdt;
	// halted bit of the one-hot state flop
	assign clock_stopped = st.fsm[2]; // RULE19
	assign peek_data = st.peek;

endmodule
`default_nettype wire

// ---- rtl/mis_defines.svh ----
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH

// system clocks in one instruction cycle
`define MIS_CYCLE_CLKS 4
// base instruction cycles
`define MIS_BASE_CYCLES 1
`define MIS_BRANCH_CYCLES 2
// extra cycle when a result lands in the program counter low byte
`define MIS_PCL_EXTRA_CYCLES 1
// data address that aliases the program counter low byte
`define MIS_PCL_ADDR 8'h02
// decimal adjust limits
`define MIS_BCD_LIMIT 4'h9
`define MIS_BCD_FIX 4'h6
// reset values
`define MIS_ACC_RESET 8'h00
`define MIS_PC_RESET 10'h000
`define MIS_WDT_RESET 8'h00
`define MIS_CLEAR_BYTE 8'h00
// watchdog prescaler width (log2 of instruction cycles per watchdog count)
`define MIS_WDT_PRESCALE_W 4

`endif

// ---- rtl/mis_pkg.sv ----
package mis_pkg;

	typedef enum logic [4:0] {
		MIS_OP_NOP = 5'h00,
		MIS_OP_SUM_CARRY_TO_WORK = 5'h01,
		MIS_OP_SUM_WITH_CARRY_TO_MEMORY = 5'h02,
		MIS_OP_SUM_TO_WORK = 5'h03,
		MIS_OP_SUM_IMMEDIATE = 5'h04,
		MIS_OP_SUM_TO_MEMORY = 5'h05,
		MIS_OP_CONJ_TO_WORK = 5'h06,
		MIS_OP_CONJ_IMMEDIATE = 5'h07,
		MIS_OP_BITWISE_CONJUNCTION_TO_MEMORY = 5'h08,
		MIS_OP_SUBROUTINE_CALL = 5'h09,
		MIS_OP_CLEAR_BYTE = 5'h0a,
		MIS_OP_CLEAR_BIT = 5'h0b,
		MIS_OP_WATCHDOG_CLEAR = 5'h0c,
		MIS_OP_GUARD_PRECLEAR_ONE = 5'h0d,
		MIS_OP_GUARD_PRECLEAR_TWO = 5'h0e,
		MIS_OP_INVERT_BITS = 5'h0f,
		MIS_OP_INVERT_BITS_TO_WORK = 5'h10,
		MIS_OP_DECIMAL_FIXUP = 5'h11,
		MIS_OP_DECREMENT = 5'h12,
		MIS_OP_DECREMENT_TO_WORK = 5'h13,
		MIS_OP_INCREMENT = 5'h14,
		MIS_OP_INCREMENT_TO_WORK = 5'h15,
		MIS_OP_POWER_DOWN = 5'h16,
		MIS_OP_DIRECT_BRANCH = 5'h17
	} mis_op_type;

	typedef enum logic [2:0] {
		MIS_FSM_IDLE = 3'b001,
		MIS_FSM_BUSY = 3'b010,
		MIS_FSM_HALTED = 3'b100
	} mis_fsm_type;

	typedef struct packed {
		logic watchdog_expired_flag;
		logic sleep_entered_flag;
		logic sign_wrap_flag;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} mis_flags_type;

	typedef struct packed {
		mis_op_type op;
		logic [7:0] addr;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [9:0] target;
	} mis_req_type;

endpackage

// ---- testbench/mis_core_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module mis_core_properties (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire mis_pkg::mis_req_type req,
	input wire logic req_ready,
	input wire logic done,
	input wire logic [7:0] work_reg,
	input wire mis_pkg::mis_flags_type flags,
	input wire logic [9:0] pc,
	input wire logic [7:0] watchdog_counter,
	input wire logic clock_stopped
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic take;
	assign take = req_valid && req_ready;
	property p_conj;
		take && req.op == mis_pkg::MIS_OP_CONJ_IMMEDIATE |=> work_reg == ($past(work_reg)
			& $past(req.imm)) && flags.zero == (work_reg == 8'h00) && $stable(flags[1:0]);
	endproperty
	a_conj: assert property (p_conj) else $error("and result or flags wrong");
	property p_sum;
		take && req.op == mis_pkg::MIS_OP_SUM_IMMEDIATE
			|=> {flags.carry, work_reg} == {1'b0, $past(work_reg)} + $past(req.imm);
	endproperty
	a_sum: assert property (p_sum) else $error("immediate sum wrong");
	property p_branch_len;
		take && req.op == mis_pkg::MIS_OP_DIRECT_BRANCH
			|=> (!req_ready && !done)[*7] ##1 done ##1 req_ready;
	endproperty
	a_branch_len: assert property (p_branch_len) else $error("jump length wrong");
	property p_one_cycle;
		take && req.op == mis_pkg::MIS_OP_SUM_TO_WORK |=> !req_ready[*3] ##1 done ##1 req_ready;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("single cycle wrong");
	property p_pcl;
		take && req.op == mis_pkg::MIS_OP_CLEAR_BYTE && req.addr == 8'h02
			|=> !req_ready[*8] ##1 req_ready;
	endproperty
	a_pcl: assert property (p_pcl) else $error("no extra cycle on pc low write");
	property p_target;
		take && (req.op == mis_pkg::MIS_OP_DIRECT_BRANCH || req.op == mis_pkg::MIS_OP_SUBROUTINE_CALL)
			|=> pc == $past(req.target) && $stable(flags[3:0]);
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");
	property p_halt;
		take && req.op == mis_pkg::MIS_OP_POWER_DOWN |=> flags[5:4] == 2'b01
			&& watchdog_counter == 8'h00 && pc == $past(pc) + 10'h001 ##4 clock_stopped;
	endproperty
	a_halt: assert property (p_halt) else $error("power down entry wrong");
	property p_wdt_clear;
		take && req.op == mis_pkg::MIS_OP_WATCHDOG_CLEAR
			|=> watchdog_counter == 8'h00 && flags[5:4] == 2'b00;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear wrong");
endmodule
bind mis_core mis_core_properties u_props (.ref_clk(ref_clk), .resetn(resetn),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
	.work_reg(work_reg), .flags(flags), .pc(pc), .watchdog_counter(watchdog_counter),
	.clock_stopped(clock_stopped));
`default_nettype wire

// ---- testbench/mis_prog_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mis_prog_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic req_ready,
	output logic req_valid,
	output mis_pkg::mis_req_type req
);
	mis_pkg::mis_req_type fifo [$];
	logic slow = 1'b0;
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// request held until taken; idle bus toggles so a stale value never matches
	always @(posedge ref_clk) begin
		if (!resetn) begin
			req_valid <= 1'b0;
		end else if (!req_valid || req_ready) begin
			if (fifo.size() > 0 && !(slow && $urandom_range(1, 0) == 1)) begin
				req_valid <= 1'b1;
				req <= fifo.pop_front();
			end else begin
				req_valid <= 1'b0;
				req <= ~req;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/tb_mis_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb_mis_core;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wake_up = 1'b0;
	logic [5:0] peek_addr = 6'h00;
	logic req_valid, req_ready, done, clock_stopped;
	mis_pkg::mis_req_type req;
	mis_pkg::mis_flags_type flags, fl;
	logic [7:0] work_reg, watchdog_counter, peek_data, acc;
	logic [9:0] pc, epc;
	logic [7:0] mem [64];
	logic [1:0] mk;
	int fails = 0, n_checks = 0, cyc = 0;
	logic [4:0] ops [17] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a,
		5'h0b, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
	mis_core #(.PRESCALE_W(1)) dut (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid),
		.req(req), .wake_up(wake_up), .peek_addr(peek_addr), .req_ready(req_ready), .done(done),
		.work_reg(work_reg), .flags(flags), .pc(pc), .watchdog_counter(watchdog_counter),
		.clock_stopped(clock_stopped), .peek_data(peek_data));
	mis_prog_model u_prog (.ref_clk(ref_clk), .resetn(resetn), .req_ready(req_ready),
		.req_valid(req_valid), .req(req));
	initial forever #50 ref_clk = ~ref_clk;
	task automatic stop_test;
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	function automatic void predict(input mis_pkg::mis_req_type r, inout logic [7:0] a, m,
		inout mis_pkg::mis_flags_type f);
		logic [7:0] x, y;
		logic [8:0] s;
		logic [4:0] lo;
		logic c1, dm, da;
		x = (r.op == 5'h04 || r.op == 5'h07) ? r.imm : m;
		c1 = r.op <= 5'h02 && f.carry;
		s = a + x + c1;
		lo = a[3:0] + x[3:0] + c1;
		y = m;
		dm = r.op inside {5'h02, 5'h05, 5'h08, 5'h0f, 5'h11, 5'h12, 5'h14};
		da = r.op inside {5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h10, 5'h13, 5'h15};
		case (r.op)
		5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
			y = s[7:0];
			f.carry = s[8];
			f.half_carry_flag = lo[4];
			f.sign_wrap_flag = a[7] == x[7] && s[7] != a[7];
		end
		5'h06, 5'h07, 5'h08: y = a & x;
		5'h0f, 5'h10: y = ~m;
		5'h12, 5'h13: y = m - 8'h01;
		5'h14, 5'h15: y = m + 8'h01;
		5'h0a: m = 8'h00;
		5'h0b: m[r.bit_sel] = 1'b0;
		5'h11: begin
			c1 = a[3:0] > 4'h9 || f.half_carry_flag;
			y[3:0] = a[3:0] + (c1 ? 4'h6 : 4'h0);
			lo = a[7:4] + (c1 && !f.half_carry_flag);
			c1 = lo > 5'h09 || f.carry;
			y[7:4] = lo[3:0] + (c1 ? 4'h6 : 4'h0);
			f.carry = c1;
		end
		5'h0c: begin
			f[5:4] = 2'b00;
			mk = 2'b00;
		end
		5'h0d, 5'h0e: begin
			mk[r.op[0]] = 1'b1;
			if (&mk) begin
				f[5:4] = 2'b00;
				mk = 2'b00;
			end
		end
		5'h16: begin
			f[5:4] = 2'b01;
			mk = 2'b00;
		end
		default: ;
		endcase
		if (dm) m = y;
		if (da) a = y;
		if (r.op != 5'h11 && (dm || da)) f.zero = y == 8'h00;
	endfunction
	task automatic run(input logic [4:0] c, input logic [7:0] ad, im, input logic [9:0] tg);
		mis_pkg::mis_req_type r;
		logic [7:0] m;
		int n;
		r = '{mis_pkg::mis_op_type'(c), ad, im, 3'($urandom), tg};
		m = mem[ad[5:0]];
		predict(r, acc, m, fl);
		mem[ad[5:0]] = m;
		epc = (c == 5'h09 || c == 5'h17) ? tg : epc + 10'h001;
		if (ad == 8'h02) epc[7:0] = m;
		@(posedge ref_clk);
		peek_addr <= ad[5:0];
		u_prog.fifo.push_back(r);
		#1;
		for (n = 0; n < 40 && done !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK("done", done, 1'b1)
		`CHK("work_reg", work_reg, acc)
		`CHK("flags", flags, fl)
		`CHK("peek_data", peek_data, m)
		`CHK("pc", pc, epc)
	endtask
	task automatic nap;
		run(5'h16, 8'h03, 8'h00, 10'h000);
		repeat (4) @(posedge ref_clk);
		wake_up <= 1'b1;
		#1;
		`CHK("halted", {clock_stopped, req_ready}, 2'b10)
		@(posedge ref_clk);
		wake_up <= 1'b0;
	endtask
	initial begin
		void'($urandom(31));
		fl = '0;
		acc = 8'h00;
		epc = 10'h000;
		mk = 2'b00;
		foreach (mem[k]) mem[k] = 8'h00;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		#1;
		`CHK("reset", {work_reg, pc, flags, req_ready, done}, {8'h00, 10'h000, 6'h00, 2'b10})
		run(5'h04, 8'h03, 8'h7f, 10'h000);
		run(5'h04, 8'h03, 8'h01, 10'h000);
		run(5'h04, 8'h03, 8'h80, 10'h000);
		for (int i = 0; i < 80; i++) begin
			u_prog.slow = i[0];
			run(ops[$urandom_range(16, 0)], 8'($urandom_range(63, 3)), 8'($urandom), 10'h000);
		end
		nap();
		repeat (4) run(5'h00, 8'h04, 8'h00, 10'h000);
		run(5'h0d, 8'h04, 8'h00, 10'h000);
		run(5'h0d, 8'h04, 8'h00, 10'h000);
		`CHK("wdt_kept", watchdog_counter != 8'h00, 1'b1)
		run(5'h0e, 8'h04, 8'h00, 10'h000);
		`CHK("wdt_clear", watchdog_counter, 8'h00)
		nap();
		run(5'h0c, 8'h04, 8'h00, 10'h000);
		run(5'h17, 8'h04, 8'h00, 10'h2a5);
		run(5'h09, 8'h04, 8'h00, 10'h155);
		run(5'h0a, 8'h02, 8'h00, 10'h000);
		stop_test();
	end
endmodule
`default_nettype wire
